/* hw/rff_defs.vh */
// register map, field positions, reset values and timing of the rx filter
`ifndef RFF_DEFS_VH
`define RFF_DEFS_VH

// register byte offsets
`define RFF_OFS_CTRL        8'h00
`define RFF_OFS_PRIM_LO     8'h08
`define RFF_OFS_PRIM_HI     8'h0C
`define RFF_OFS_STATUS      8'h10
`define RFF_OFS_DROPS       8'h14
`define RFF_SUPP_REGION     3'h1
`define RFF_OFS_SUPP_BASE   8'h20

// control register fields
`define RFF_BIT_ALL_UCAST   0
`define RFF_BIT_ALL_MCAST   1
`define RFF_BIT_PASS_CTRL   3
`define RFF_BIT_PASS_PAUSE  4
`define RFF_BIT_IGN_PAUSE   5
`define RFF_BIT_SUPP_LO     16
`define RFF_CTRL_RESET      32'h0000_0003
`define RFF_CTRL_WR_MASK    32'h000F_003B

// status register fields
`define RFF_BIT_PAUSED      16

// frame classification
`define RFF_ETYPE_MAC_CTRL  16'h8808
`define RFF_OPC_PAUSE       16'h0001
`define RFF_OPC_PFC         16'h0101
`define RFF_ADDR_BCAST      48'hFFFF_FFFF_FFFF
`define RFF_GROUP_BIT       40

// pause timing: one quantum is 512 bit times on the line
`define RFF_QUANTUM_BITS    512
`define RFF_LINE_MBPS       10000
`define RFF_CLK_MHZ         125
// least time, so round up to whole cycles
`define RFF_QUANTUM_CYCLES  ((`RFF_QUANTUM_BITS * `RFF_CLK_MHZ + \
	`RFF_LINE_MBPS - 1) / `RFF_LINE_MBPS)

`endif

/* hw/rff_rx_filter.v */
// receive frame filter: address filter, control/pause handling, apb regs
`timescale 1ns/1ps
`include "rff_defs.vh"

module rff_rx_filter #(
	parameter DATA_W   = 64,
	parameter PFC_ON   = 0,
	parameter N_SUPP   = 4
) (
	input  wire              core_clk,
	input  wire              reset_n,
	// apb slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [7:0]        paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	// frame stream from the phy side, header fields valid on first beat
	input  wire              in_valid,
	input  wire              in_first,
	input  wire              in_last,
	input  wire [DATA_W-1:0] in_data,
	input  wire [47:0]       in_dst_addr,
	input  wire [15:0]       in_eth_type,
	input  wire [15:0]       in_opcode,
	input  wire [15:0]       in_quanta,
	output wire              in_ready,
	// frame stream to the client
	output wire              out_valid,
	output wire              out_last,
	output wire [DATA_W-1:0] out_data,
	input  wire              out_ready,
	// transmit suspend toward the tx path
	output reg               tx_paused
);

	// the defs count is a plain integer; cut to the timer width on purpose
	localparam integer Q_CYC_INT = `RFF_QUANTUM_CYCLES;
	localparam [15:0]  Q_CYC     = Q_CYC_INT[15:0];

	reg  [31:0]       ctrl;
	reg  [47:0]       prim_addr;
	reg  [47:0]       supp_addr [0:N_SUPP-1];
	reg  [15:0]       pause_left;
	reg  [15:0]       q_div;
	reg  [31:0]       drop_count;
	reg               frame_keep;
	reg  [31:0]       next_rdata;
	reg               next_err;
	wire [N_SUPP-1:0] supp_hit;
	wire              accept_all_unicast;
	wire              accept_all_multicast;
	wire              pass_control_frames;
	wire              pass_pause_frames;
	wire              ignore_pause;
	wire [N_SUPP-1:0] supp_on;
	wire              is_mcast;
	wire              is_bcast;
	wire              is_ctrl;
	wire              is_pause;
	wire              is_pfc;
	wire              uc_match;
	reg               keep_now;
	wire              take;
	wire              sof_take;
	wire              fwd_beat;
	wire              buf_ready;
	wire              q_tick;
	wire              pause_load;
	wire              setup;
	wire              access;
	wire              wr_en;
	wire              supp_sel;

	////////////////////////////////////////////////////////////////////
	// control fields
	assign accept_all_unicast   = ctrl[`RFF_BIT_ALL_UCAST];
	assign accept_all_multicast = ctrl[`RFF_BIT_ALL_MCAST];
	assign pass_control_frames  = ctrl[`RFF_BIT_PASS_CTRL];
	assign pass_pause_frames    = ctrl[`RFF_BIT_PASS_PAUSE];
	assign ignore_pause         = ctrl[`RFF_BIT_IGN_PAUSE];
	assign supp_on = ctrl[`RFF_BIT_SUPP_LO +: N_SUPP];

	////////////////////////////////////////////////////////////////////
	// frame classification from header fields
	assign is_mcast = in_dst_addr[`RFF_GROUP_BIT];
	assign is_bcast = (in_dst_addr == `RFF_ADDR_BCAST);
	assign is_ctrl  = (in_eth_type == `RFF_ETYPE_MAC_CTRL);
	assign is_pause = is_ctrl && (in_opcode == `RFF_OPC_PAUSE);
	assign is_pfc   = is_ctrl && (PFC_ON != 0) &&
		(in_opcode == `RFF_OPC_PFC);

	// one comparator per supplementary address
	genvar gi;
	generate
		for (gi = 0; gi < N_SUPP; gi = gi + 1) begin : g_supp
			// a disabled entry never matches
			assign supp_hit[gi] = supp_on[gi] &&
				(in_dst_addr == supp_addr[gi]);
		end
	endgenerate

	assign uc_match = (in_dst_addr == prim_addr) || (|supp_hit);

	////////////////////////////////////////////////////////////////////
	// keep/drop decision on the first beat; control frames bypass the
	// address filter since pause uses a reserved multicast address
	always @* begin
		keep_now = 1'b0;
		if (is_pause) begin
			keep_now = pass_pause_frames;
		end else if (is_pfc) begin
			keep_now = 1'b1;
		end else if (is_ctrl) begin
			keep_now = pass_control_frames;
		end else if (is_bcast) begin
			keep_now = 1'b1;
		end else if (is_mcast) begin
			keep_now = accept_all_multicast;
		end else begin
			// all-unicast accepts without any compare
			keep_now = accept_all_unicast | uc_match;
		end
	end

	////////////////////////////////////////////////////////////////////
	// datapath: dropped beats are consumed but never pushed; they still
	// wait for buffer ready, so a stalled client holds up dropped frames too
	assign in_ready = buf_ready;
	assign take     = in_valid & buf_ready;
	assign sof_take = take & in_first;
	assign fwd_beat = in_valid & (in_first ? keep_now : frame_keep);

	always @(posedge core_clk) begin
		if (!reset_n) begin
			frame_keep <= 1'b0;
		end else if (sof_take) begin
			frame_keep <= keep_now;
		end
	end

	rff_skid_buf #(
		.WIDTH     (DATA_W + 1)
	) u_buf (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.in_valid  (fwd_beat),
		.in_data   ({in_last, in_data}),
		.in_ready  (buf_ready),
		.out_valid (out_valid),
		.out_data  ({out_last, out_data}),
		.out_ready (out_ready)
	);

	// counts frames rejected by any filter stage
	always @(posedge core_clk) begin
		if (!reset_n) begin
			drop_count <= 32'h0000_0000;
		end else if (sof_take && !keep_now) begin
			drop_count <= drop_count + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pause timer: quantum divider gives a one-cycle enable
	assign q_tick     = (q_div == Q_CYC - 16'h0001);
	assign pause_load = sof_take && is_pause && !ignore_pause;

	// a reload restarts the quantum, else the first one could come short
	always @(posedge core_clk) begin
		if (!reset_n) begin
			q_div <= 16'h0000;
		end else if (pause_load || q_tick || pause_left == 16'h0000) begin
			q_div <= 16'h0000;
		end else begin
			q_div <= q_div + 16'h0001;
		end
	end

	// a new pause frame reloads the timer, quanta of zero resumes now
	always @(posedge core_clk) begin
		if (!reset_n) begin
			pause_left <= 16'h0000;
			tx_paused  <= 1'b0;
		end else if (pause_load) begin
			pause_left <= in_quanta;
			tx_paused  <= (in_quanta != 16'h0000);
		end else if (q_tick && pause_left != 16'h0000) begin
			// frames under disregard never reach here
			pause_left <= pause_left - 16'h0001;
			tx_paused  <= (pause_left != 16'h0001);
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb: one wait state, answer prepared during setup
	assign setup    = psel & ~penable;
	assign access   = psel & penable & pready;
	assign wr_en    = access & pwrite & ~pslverr;
	assign supp_sel = (paddr[7:5] == `RFF_SUPP_REGION) &&
		(paddr[1:0] == 2'b00) && (paddr[4:3] < N_SUPP);

	// read mux and address decode
	always @* begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		if (supp_sel) begin
			next_rdata = paddr[2] ? {16'h0000, supp_addr[paddr[4:3]][47:32]}
				: supp_addr[paddr[4:3]][31:0];
		end else begin
			case (paddr)
				`RFF_OFS_CTRL:
					next_rdata = ctrl & `RFF_CTRL_WR_MASK;
				`RFF_OFS_PRIM_LO:
					next_rdata = prim_addr[31:0];
				`RFF_OFS_PRIM_HI:
					next_rdata = {16'h0000, prim_addr[47:32]};
				`RFF_OFS_STATUS:
					next_rdata = {15'h0000, tx_paused, pause_left};
				`RFF_OFS_DROPS:
					next_rdata = drop_count;
				default:
					next_err = 1'b1;
			endcase
		end
		// status registers are read-only
		if (pwrite && (paddr == `RFF_OFS_STATUS ||
			paddr == `RFF_OFS_DROPS)) begin
			next_err = 1'b1;
		end
	end

	always @(posedge core_clk) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready;
			if (setup) begin
				pslverr <= next_err;
				prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
			end else if (access) begin
				pslverr <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// writable registers; reserved bits are masked off on write
	always @(posedge core_clk) begin
		if (!reset_n) begin
			ctrl      <= `RFF_CTRL_RESET;
			prim_addr <= 48'h0000_0000_0000;
		end else if (wr_en) begin
			if (paddr == `RFF_OFS_CTRL) begin
				ctrl <= pwdata & `RFF_CTRL_WR_MASK;
			end
			if (paddr == `RFF_OFS_PRIM_LO) begin
				prim_addr[31:0] <= pwdata;
			end
			if (paddr == `RFF_OFS_PRIM_HI) begin
				prim_addr[47:32] <= pwdata[15:0];
			end
		end
	end

	// one write port per supplementary address entry
	generate
		for (gi = 0; gi < N_SUPP; gi = gi + 1) begin : g_supp_wr
			always @(posedge core_clk) begin
				if (!reset_n) begin
					supp_addr[gi] <= 48'h0000_0000_0000;
				end else if (wr_en && supp_sel && paddr[4:3] == gi) begin
					if (paddr[2]) begin
						supp_addr[gi][47:32] <= pwdata[15:0];
					end else begin
						supp_addr[gi][31:0] <= pwdata;
					end
				end
			end
		end
	endgenerate

endmodule // rff_rx_filter

/* hw/rff_skid_buf.v */
// two-entry skid buffer, outputs straight from flip-flops
`timescale 1ns/1ps

module rff_skid_buf #(
	parameter WIDTH = 65
) (
	input  wire             core_clk,
	input  wire             reset_n,
	input  wire             in_valid,
	input  wire [WIDTH-1:0] in_data,
	output reg              in_ready,
	output reg              out_valid,
	output reg  [WIDTH-1:0] out_data,
	input  wire             out_ready
);

	reg             skid_valid;
	reg [WIDTH-1:0] skid_data;
	wire            push;

	assign push = in_valid & in_ready;

	////////////////////////////////////////////////////////////////////
	// head register drains first; the skid slot catches the word that
	// was already in flight when the receiver stalled
	always @(posedge core_clk) begin
		if (!reset_n) begin
			out_valid  <= 1'b0;
			out_data   <= {WIDTH{1'b0}};
			skid_valid <= 1'b0;
			skid_data  <= {WIDTH{1'b0}};
			in_ready   <= 1'b0;
		end else begin
			if (!out_valid || out_ready) begin
				if (skid_valid) begin
					out_valid  <= 1'b1;
					out_data   <= skid_data;
					skid_valid <= push;
					skid_data  <= in_data;
				end else begin
					out_valid <= push;
					out_data  <= in_data;
				end
			end else if (push) begin
				skid_valid <= 1'b1;
				skid_data  <= in_data;
			end
			// ready is registered so the source never sees a comb path
			in_ready <= ~(skid_valid ? ~(!out_valid || out_ready) | push
				: (out_valid && !out_ready && push));
		end
	end

endmodule // rff_skid_buf

/* tb/rff_client_model.sv */
// client model: collects delivered beats, can stall
`timescale 1ns/1ps
module rff_client_model (
	input  wire        core_clk,
	input  wire        reset_n,
	input  wire        out_valid,
	input  wire [63:0] out_data,
	input  wire        out_last,
	input  wire        stall,
	output reg         out_ready
);
	logic [63:0] got[$];
	logic        lasts[$];
	reg   [1:0]  ph;
	// one idle cycle in four even when free, so delivery is never eased
	always @(posedge core_clk) begin
		ph <= reset_n ? ph + 2'h1 : 2'h0;
		out_ready <= reset_n && !stall && ph != 2'h3;
		if (reset_n && out_valid && out_ready) begin
			got.push_back(out_data);
			lasts.push_back(out_last);
		end
	end
endmodule // rff_client_model

/* tb/rff_rx_filter_chk.sv */
// port assertions for the receive frame filter
`timescale 1ns/1ps
module rff_rx_filter_chk #(
	parameter DATA_W = 64
) (
	input wire              core_clk,
	input wire              reset_n,
	input wire              psel,
	input wire              penable,
	input wire              pwrite,
	input wire [7:0]        paddr,
	input wire [31:0]       pwdata,
	input wire [31:0]       prdata,
	input wire              pready,
	input wire              in_valid,
	input wire              in_ready,
	input wire              in_first,
	input wire [15:0]       in_eth_type,
	input wire [15:0]       in_opcode,
	input wire [15:0]       in_quanta,
	input wire              out_valid,
	input wire              out_last,
	input wire [DATA_W-1:0] out_data,
	input wire              out_ready,
	input wire              tx_paused
);
	reg  [31:0] shadow;
	wire        take;
	wire        rd0;
	// a pause header taken on the input side
	assign take = in_valid && in_ready && in_first &&
		in_eth_type == 16'h8808 && in_opcode == 16'h0001;
	assign rd0 = psel && penable && pready && !pwrite && paddr == 8'h00;
	// shadow of the control word, so reads can be judged without the body
	always @(posedge core_clk) begin
		if (!reset_n)
			shadow <= 32'h0000_0003;
		else if (psel && penable && pready && pwrite && paddr == 8'h00)
			shadow <= pwdata & 32'h000F_003B;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_pready_lat: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not on second access cycle");
	a_ctrl_read: assert property (rd0 |-> prdata == shadow)
		else $error("control readback wrong");
	a_rsvd_zero: assert property (rd0 |-> !(prdata & 32'hFFF0_FFC4))
		else $error("reserved bits not zero");
	a_out_hold: assert property (out_valid && !out_ready |=>
		out_valid && $stable(out_data) && $stable(out_last))
		else $error("output beat changed while stalled");
	a_pause_halt: assert property (take && !shadow[5] && in_quanta != 0
		|=> tx_paused) else $error("pause did not halt");
	a_pause_len: assert property (take && !shadow[5] && in_quanta == 3
		|=> tx_paused[*8] ##1 tx_paused[*8] ##1 tx_paused[*4]
		##[1:3] !tx_paused)
		else $error("pause length wrong");
	a_pause_ign: assert property (take && shadow[5] && !tx_paused
		|=> !tx_paused) else $error("ignored pause took effect");
endmodule // rff_rx_filter_chk
bind rff_rx_filter rff_rx_filter_chk #(.DATA_W(DATA_W)) u_chk (
	.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .in_valid(in_valid), .in_ready(in_ready),
	.in_first(in_first), .in_eth_type(in_eth_type), .in_opcode(in_opcode),
	.in_quanta(in_quanta), .out_valid(out_valid), .out_last(out_last),
	.out_data(out_data), .out_ready(out_ready), .tx_paused(tx_paused));

/* tb/test_rx_frame_filter_control.sv */
// testbench for the receive frame filter
`timescale 1ns/1ps
module test_rx_frame_filter_control;
	localparam [47:0] ua = 48'h0200_0000_000A, ub = 48'h0200_0000_000B;
	localparam [47:0] mc = 48'h0100_5E00_0001, cd = 48'h0180_C200_0001;
	reg         core_clk, reset_n, psel, penable, pwrite, stall, rerr;
	reg         in_valid, in_first, in_last;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata, rdat;
	reg  [63:0] in_data;
	reg  [47:0] in_dst_addr;
	reg  [15:0] in_eth_type, in_opcode, in_quanta;
	wire [31:0] prdata;
	wire        pready, pslverr, in_ready, out_valid, out_last, out_ready;
	wire        tx_paused;
	wire [63:0] out_data;
	int         error_cnt, check_count, n, k, base;

	rff_rx_filter u_rff_rx_filter (.core_clk(core_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.in_valid(in_valid), .in_first(in_first), .in_last(in_last),
		.in_data(in_data), .in_dst_addr(in_dst_addr), .in_eth_type(in_eth_type),
		.in_opcode(in_opcode), .in_quanta(in_quanta), .in_ready(in_ready),
		.out_valid(out_valid), .out_last(out_last), .out_data(out_data),
		.out_ready(out_ready), .tx_paused(tx_paused));
	rff_client_model u_rff_client_model (.core_clk(core_clk),
		.reset_n(reset_n), .out_valid(out_valid), .out_data(out_data),
		.out_last(out_last), .stall(stall), .out_ready(out_ready));

	initial begin
		core_clk = 0;
		forever #4 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task end_sim;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input [63:0] got, input [63:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; the request stands until pready is seen
	task apb(input w, input [7:0] a, input [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		n = 0;
		do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			$display("Error at %0t: no pready", $time);
			error_cnt++;
			end_sim;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge core_clk);
	endtask
	// one single-beat frame, then count what reached the client
	task fr(input [47:0] d, input [15:0] t, o, q, input [63:0] exp);
		base = u_rff_client_model.got.size();
		{in_valid, in_first, in_last} <= 3'h7;
		in_dst_addr <= d;
		in_eth_type <= t;
		in_opcode <= o;
		in_quanta <= q;
		in_data <= {d, t};
		n = 0;
		do begin @(posedge core_clk); n++; end while (in_ready !== 1'b1 && n < 20);
		if (in_ready !== 1'b1) begin
			$display("Error at %0t: input never ready", $time);
			error_cnt++;
			end_sim;
		end
		in_valid <= 0;
		repeat (8) @(posedge core_clk);
		chk(u_rff_client_model.got.size() - base, exp);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, stall, in_valid, in_first, in_last} <= 0;
		{paddr, pwdata, in_data, in_dst_addr} <= 0;
		{in_eth_type, in_opcode, in_quanta} <= 0;
		reset_n <= 0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1;
		@(posedge core_clk);
		apb(0, 8'h00, 0); chk(rdat, 32'h0000_0003);
		apb(1, 8'h00, 32'hFFFF_FFFF);
		apb(0, 8'h00, 0); chk(rdat, 32'h000F_003B);
		apb(0, 8'h40, 0); chk(rerr, 1);
		$display("register test done");
		apb(1, 8'h00, 3);
		fr(ub, 16'h0800, 0, 0, 1);
		fr(mc, 16'h0800, 0, 0, 1);
		apb(1, 8'h08, 32'h0000_000A);
		apb(1, 8'h0C, 32'h0000_0200);
		apb(1, 8'h20, 32'h0000_000B);
		apb(1, 8'h24, 32'h0000_0200);
		apb(1, 8'h00, 0);
		fr(ua, 16'h0800, 0, 0, 1);
		fr(ub, 16'h0800, 0, 0, 0);
		fr(mc, 16'h0800, 0, 0, 0);
		apb(1, 8'h00, 32'h0001_0000);
		fr(ub, 16'h0800, 0, 0, 1);
		apb(1, 8'h00, 1);
		fr(ub, 16'h0800, 0, 0, 1);
		apb(1, 8'h00, 2);
		fr(mc, 16'h0800, 0, 0, 1);
		$display("filter test done");
		apb(1, 8'h00, 3);
		fr(cd, 16'h8808, 16'h0002, 0, 0);
		fr(cd, 16'h8808, 16'h0101, 0, 0);
		apb(1, 8'h00, 32'h0000_000B);
		fr(cd, 16'h8808, 16'h0002, 0, 1);
		fr(cd, 16'h8808, 16'h0001, 3, 0);
		chk(tx_paused, 1);
		repeat (20) @(posedge core_clk);
		chk(tx_paused, 0);
		apb(1, 8'h00, 32'h0000_0013);
		fr(cd, 16'h8808, 16'h0001, 3, 1);
		chk(tx_paused, 1);
		repeat (20) @(posedge core_clk);
		apb(1, 8'h00, 32'h0000_0033);
		fr(cd, 16'h8808, 16'h0001, 3, 1);
		chk(tx_paused, 0);
		apb(1, 8'h10, 0); chk(rerr, 1);
		apb(0, 8'h14, 0); chk(rdat, 5);
		$display("control test done");
		// stalled client: input must refuse once the buffer is full
		apb(1, 8'h00, 3);
		base = u_rff_client_model.got.size();
		stall <= 1;
		k = 0;
		{in_valid, in_first, in_last} <= 3'h6;
		in_eth_type <= 16'h0800;
		in_data <= 0;
		repeat (20) begin
			@(posedge core_clk);
			if (in_ready === 1'b1) begin
				k++;
				in_data <= 64'(k);
				in_first <= !k[0];
				in_last <= k[0];
			end
		end
		chk(in_ready, 0);
		chk(k, 2);
		in_valid <= 0;
		stall <= 0;
		repeat (40) @(posedge core_clk);
		chk(u_rff_client_model.got.size() - base, k);
		for (n = 0; n < k; n++) begin
			chk(u_rff_client_model.got[base + n], 64'(n));
			chk(u_rff_client_model.lasts[base + n], n[0]);
		end
		$display("stall test done");
		end_sim;
	end
endmodule // test_rx_frame_filter_control
